// ### shared/tacs_pkg.sv
// Package of constants shared by the reader and card ends of the link.
package tacs_pkg;
  localparam logic [7:0] TACS_REQ = 8'h26;
  localparam logic [7:0] TACS_SEL_L1 = 8'h93;
  localparam logic [7:0] TACS_SEL_L2 = 8'h95;
  localparam logic [7:0] TACS_SEL_L3 = 8'h97;
  localparam logic [7:0] TACS_NVB_AC = 8'h20;
  localparam logic [7:0] TACS_NVB_SEL = 8'h70;
  localparam logic [7:0] TACS_CT = 8'h88;
  localparam logic [15:0] TACS_CRC_INIT = 16'h6363;
  localparam logic [15:0] TACS_CRC_POLY = 16'h8408;
  localparam logic [1:0] TACS_SIZE_SINGLE = 2'h0;
  localparam logic [1:0] TACS_SIZE_DOUBLE = 2'h1;
  localparam logic [1:0] TACS_SIZE_TRIPLE = 2'h2;
  localparam int TACS_ATQA_B87_LSB = 6;
  localparam int TACS_SAK_CASCADE = 2;
  localparam logic [7:0] TACS_SAK_CASC = 8'h04;
  localparam logic [7:0] TACS_SAK_DONE = 8'h08;
  localparam logic [15:0] TACS_ATQA_BASE = 16'h0004;
  localparam logic [3:0] TACS_CMD_AC_LEN = 4'h2;
  localparam logic [3:0] TACS_CMD_SEL_LEN = 4'h7;
  localparam logic [3:0] TACS_UID_LEN = 4'h5;
  localparam int TACS_CLK_HZ = 40000000;
  localparam int TACS_FDT_NS = 90000;
  localparam int TACS_FDT_CYC = (TACS_FDT_NS * (TACS_CLK_HZ / 1000000)
    + 999) / 1000;
  localparam int TACS_RGT_NS = 7000;
  localparam int TACS_RGT_CYC = (TACS_RGT_NS * (TACS_CLK_HZ / 1000000)
    + 999) / 1000;
  localparam int TACS_TMO_NS = 100000;
  localparam int TACS_TMO_CYC = (TACS_TMO_NS * (TACS_CLK_HZ / 1000000))
    / 1000;
endpackage

// ### shared/tacs_link_if.sv
// Byte-level stand-in for the air link between reader and card.
`timescale 1ns/1ps
interface tacs_link_if;
  logic [7:0] rd_byte;
  logic rd_valid;
  logic rd_last;
  logic [7:0] cd_byte;
  logic cd_valid;
  logic cd_last;
  logic [15:0] cd_coll;
  modport reader (output rd_byte, output rd_valid, output rd_last,
    input cd_byte, input cd_valid, input cd_last, input cd_coll);
  modport card (input rd_byte, input rd_valid, input rd_last,
    output cd_byte, output cd_valid, output cd_last, output cd_coll);
endinterface

// ### rtl/tacs_reader.sv
// Reader end: request, cascade anticollision and select sequencer.
`timescale 1ns/1ps
module tacs_reader
  import tacs_pkg::*;
#(
  parameter int FDT_CYC = TACS_FDT_CYC,
  parameter int RGT_CYC = TACS_RGT_CYC,
  parameter int TMO_CYC = TACS_TMO_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  tacs_link_if.reader link,
  input wire logic start,
  output logic busy,
  output logic selected,
  output logic failed,
  output logic [79:0] uid,
  output logic [1:0] uid_size,
  output logic [7:0] sak
);
  typedef enum logic [6:0] {
    TACS_IDLE = 7'h01, TACS_WAIT = 7'h02, TACS_SEND = 7'h04,
    TACS_RECV = 7'h08, TACS_CRC = 7'h10, TACS_DONE = 7'h20,
    TACS_FAIL = 7'h40
  } tacs_state_t;
  typedef enum logic [2:0] {
    TACS_PH_REQ = 3'h1, TACS_PH_AC = 3'h2, TACS_PH_SEL = 3'h4
  } tacs_phase_t;

  tacs_state_t state_reg;
  tacs_phase_t phase_reg;
  logic [31:0] timer_reg;
  logic [3:0] idx_reg;
  logic [1:0] level_reg;
  logic [7:0] uidb_reg [0:4];
  logic [15:0] crc_reg;
  logic crc_hi_reg;
  logic [7:0] rx0_reg;

  wire [7:0] sel_code = (level_reg == 2'h0) ? TACS_SEL_L1 :
    (level_reg == 2'h1) ? TACS_SEL_L2 : TACS_SEL_L3;
  wire [3:0] tx_len = (phase_reg == TACS_PH_REQ) ? 4'h1 :
    (phase_reg == TACS_PH_AC) ? TACS_CMD_AC_LEN : TACS_CMD_SEL_LEN;
  wire [7:0] sel_data = (idx_reg == 4'h0) ? sel_code :
    (idx_reg == 4'h1) ? TACS_NVB_SEL : uidb_reg[3'(idx_reg - 4'h2)];
  wire [7:0] tx_data = (phase_reg == TACS_PH_REQ) ? TACS_REQ :
    (phase_reg == TACS_PH_AC) ?
      ((idx_reg == 4'h0) ? sel_code : TACS_NVB_AC) : sel_data;
  wire tx_end = (idx_reg == tx_len - 4'h1);
  wire is_sel = (phase_reg == TACS_PH_SEL);
  wire [7:0] bcc = uidb_reg[0] ^ uidb_reg[1] ^ uidb_reg[2] ^ uidb_reg[3];
  wire bcc_ok = (bcc == link.cd_byte);
  wire [1:0] atqa_size = rx0_reg[TACS_ATQA_B87_LSB +: 2];
  wire sak_casc = link.cd_byte[TACS_SAK_CASCADE];
  wire [2:0] n_lvls = (uid_size == TACS_SIZE_SINGLE) ? 3'h1 :
    (uid_size == TACS_SIZE_DOUBLE) ? 3'h2 : 3'h3;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ TACS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire timer_done = (timer_reg == 32'h0);
  wire [31:0] timer_dec = timer_reg - 32'h1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TACS_IDLE;
      phase_reg <= TACS_PH_REQ;
      timer_reg <= 32'h0;
      idx_reg <= 4'h0;
      level_reg <= 2'h0;
      crc_reg <= TACS_CRC_INIT;
      crc_hi_reg <= 1'b0;
      rx0_reg <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        uidb_reg[i] <= 8'h00;
      end
      link.rd_byte <= 8'h00;
      link.rd_valid <= 1'b0;
      link.rd_last <= 1'b0;
      busy <= 1'b0;
      selected <= 1'b0;
      failed <= 1'b0;
      uid <= 80'h0;
      uid_size <= TACS_SIZE_SINGLE;
      sak <= 8'h00;
    end else begin
      link.rd_valid <= 1'b0;
      link.rd_last <= 1'b0;
      if (!timer_done) begin
        timer_reg <= timer_dec;
      end
      case (state_reg)
        TACS_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            selected <= 1'b0;
            failed <= 1'b0;
            level_reg <= 2'h0;
            phase_reg <= TACS_PH_REQ;
            uid <= 80'h0;
            // The reply delay keeps running, so no request follows a card
            // frame too soon.
            state_reg <= TACS_WAIT;
          end
        end
        TACS_WAIT: begin
          // The wait covers the reply-to-frame delay; the guard between requests
          // comes from the reply timeout loaded after a request, so no frame starts early.
          if (timer_done) begin
            idx_reg <= 4'h0;
            crc_reg <= TACS_CRC_INIT;
            state_reg <= TACS_SEND;
          end
        end
        TACS_SEND: begin
          link.rd_byte <= tx_data;
          link.rd_valid <= 1'b1;
          crc_reg <= crc_step(crc_reg, tx_data);
          idx_reg <= idx_reg + 4'h1;
          if (tx_end) begin
            if (is_sel) begin
              crc_hi_reg <= 1'b0;
              state_reg <= TACS_CRC;
            end else begin
              link.rd_last <= 1'b1;
              idx_reg <= 4'h0;
              timer_reg <= 32'(RGT_CYC + TMO_CYC);
              state_reg <= TACS_RECV;
            end
          end
        end
        TACS_CRC: begin
          link.rd_byte <= crc_hi_reg ? crc_reg[15:8] : crc_reg[7:0];
          link.rd_valid <= 1'b1;
          crc_hi_reg <= 1'b1;
          if (crc_hi_reg) begin
            link.rd_last <= 1'b1;
            idx_reg <= 4'h0;
            timer_reg <= 32'(TMO_CYC);
            state_reg <= TACS_RECV;
          end
        end
        TACS_RECV: begin
          if (link.cd_valid) begin
            idx_reg <= idx_reg + 4'h1;
            if (phase_reg == TACS_PH_REQ) begin
              if (idx_reg == 4'h0) begin
                rx0_reg <= link.cd_byte;
              end
            end else if (phase_reg == TACS_PH_AC) begin
              uidb_reg[idx_reg[2:0]] <= link.cd_byte;
            end else begin
              sak <= link.cd_byte;
            end
            if (link.cd_last) begin
              timer_reg <= 32'(FDT_CYC);
              state_reg <= TACS_WAIT;
              case (phase_reg)
                TACS_PH_REQ: begin
                  // Collided answer bits still lead into the loop.
                  phase_reg <= TACS_PH_AC;
                  uid_size <= (atqa_size == TACS_SIZE_SINGLE) ?
                    TACS_SIZE_SINGLE : (atqa_size == TACS_SIZE_DOUBLE) ?
                    TACS_SIZE_DOUBLE : TACS_SIZE_TRIPLE;
                end
                TACS_PH_AC: begin
                  if (idx_reg == TACS_UID_LEN - 4'h1 && bcc_ok) begin
                    phase_reg <= TACS_PH_SEL;
                  end else begin
                    state_reg <= TACS_FAIL;
                  end
                end
                default: begin
                  uid <= {uid[47:0], uidb_reg[0], uidb_reg[1],
                    uidb_reg[2], uidb_reg[3]};
                  if (!sak_casc) begin
                    state_reg <= TACS_DONE;
                  end else if (3'({1'b0, level_reg}) + 3'h1 < n_lvls) begin
                    level_reg <= level_reg + 2'h1;
                    phase_reg <= TACS_PH_AC;
                  end else begin
                    state_reg <= TACS_FAIL;
                  end
                end
              endcase
            end
          end else if (timer_done) begin
            if (phase_reg == TACS_PH_REQ) begin
              state_reg <= TACS_WAIT;
            end else begin
              state_reg <= TACS_FAIL;
            end
          end
        end
        TACS_DONE: begin
          selected <= 1'b1;
          busy <= 1'b0;
          state_reg <= TACS_IDLE;
        end
        TACS_FAIL: begin
          failed <= 1'b1;
          busy <= 1'b0;
          state_reg <= TACS_IDLE;
        end
        default: begin
          state_reg <= TACS_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rtl/tacs_card.sv
// Card end: answers request, anticollision and select frames.
`timescale 1ns/1ps
module tacs_card
  import tacs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tacs_link_if.card link,
  input wire logic [79:0] card_uid,
  input wire logic [1:0] card_size,
  input wire logic mute,
  input wire logic [15:0] coll_mask,
  output logic card_selected
);
  logic [3:0] rxn_reg;
  logic [7:0] cmd_reg;
  logic [7:0] nvb_reg;
  logic [3:0] txn_reg;
  logic [3:0] txlen_reg;
  logic [7:0] txb_reg [0:4];

  wire [1:0] lvl = (cmd_reg == TACS_SEL_L1) ? 2'h0 :
    (cmd_reg == TACS_SEL_L2) ? 2'h1 : 2'h2;
  wire [2:0] n_lvls = (card_size == TACS_SIZE_SINGLE) ? 3'h1 :
    (card_size == TACS_SIZE_DOUBLE) ? 3'h2 : 3'h3;
  wire last_lvl = (3'({1'b0, lvl}) + 3'h1 == n_lvls);
  wire [6:0] base = 7'(n_lvls - 3'h1 - 3'({1'b0, lvl})) * 7'd24;
  wire [31:0] part = card_uid[base +: 32];
  wire [7:0] u0 = last_lvl ? part[31:24] : TACS_CT;
  wire [7:0] u1 = last_lvl ? part[23:16] : part[31:24];
  wire [7:0] u2 = last_lvl ? part[15:8] : part[23:16];
  wire [7:0] u3 = last_lvl ? part[7:0] : part[15:8];
  wire [7:0] ubcc = u0 ^ u1 ^ u2 ^ u3;
  wire [15:0] atqa = TACS_ATQA_BASE |
    {8'h00, card_size, 6'h00};
  wire is_req = (rxn_reg == 4'h0) && (link.rd_byte == TACS_REQ);
  wire is_ac = (rxn_reg == 4'h1) ? (link.rd_byte == TACS_NVB_AC) :
    (nvb_reg == TACS_NVB_AC);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxn_reg <= 4'h0;
      cmd_reg <= 8'h00;
      nvb_reg <= 8'h00;
      txn_reg <= 4'h0;
      txlen_reg <= 4'h0;
      for (int i = 0; i < 5; i++) begin
        txb_reg[i] <= 8'h00;
      end
      link.cd_byte <= 8'h00;
      link.cd_valid <= 1'b0;
      link.cd_last <= 1'b0;
      link.cd_coll <= 16'h0;
      card_selected <= 1'b0;
    end else begin
      link.cd_valid <= 1'b0;
      link.cd_last <= 1'b0;
      if (txn_reg != txlen_reg) begin
        link.cd_byte <= txb_reg[txn_reg[2:0]];
        link.cd_valid <= 1'b1;
        link.cd_last <= (txn_reg + 4'h1 == txlen_reg);
        // Parity shares the data bit's collision flag in this model.
        link.cd_coll <= (txlen_reg == 4'h2) ? coll_mask : 16'h0;
        txn_reg <= txn_reg + 4'h1;
      end
      if (link.rd_valid) begin
        rxn_reg <= link.rd_last ? 4'h0 : rxn_reg + 4'h1;
        if (rxn_reg == 4'h0) begin
          cmd_reg <= link.rd_byte;
        end
        if (rxn_reg == 4'h1) begin
          nvb_reg <= link.rd_byte;
        end
        if (link.rd_last && !mute) begin
          txn_reg <= 4'h0;
          if (is_req) begin
            card_selected <= 1'b0;
            txb_reg[0] <= atqa[7:0];
            txb_reg[1] <= atqa[15:8];
            txlen_reg <= 4'h2;
          end else if (is_ac) begin
            txb_reg[0] <= u0;
            txb_reg[1] <= u1;
            txb_reg[2] <= u2;
            txb_reg[3] <= u3;
            txb_reg[4] <= ubcc;
            txlen_reg <= TACS_UID_LEN;
          end else begin
            txb_reg[0] <= last_lvl ? TACS_SAK_DONE : TACS_SAK_CASC;
            card_selected <= last_lvl;
            txlen_reg <= 4'h1;
          end
        end
      end
    end
  end
endmodule

// ### tb/tacs_properties.sv
// Concurrent checks on the byte link between the reader and card ends.
`timescale 1ns/1ps
module tacs_properties
  import tacs_pkg::*;
#(
  parameter int FDT_CYC = 20,
  parameter int RGT_CYC = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic rd_last,
  input wire logic [7:0] cd_byte,
  input wire logic cd_valid,
  input wire logic cd_last,
  input wire logic [15:0] cd_coll
);
  localparam int NEXT_MAX = FDT_CYC + 100;
  logic [3:0] idx_reg;
  logic [3:0] cd_idx_reg;
  logic [7:0] code_reg;
  logic [7:0] acc_reg;
  logic sel_reg;
  logic [15:0] fdt_reg;
  logic [15:0] rgt_reg;
  wire first_w = rd_valid && idx_reg == 4'h0;
  wire req_w = first_w && rd_byte == TACS_REQ;
  wire nvb_w = rd_valid && idx_reg == 4'h1;
  // Gap counters saturate so that a long idle never wraps to a short gap.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_reg <= 4'h0;
      cd_idx_reg <= 4'h0;
      code_reg <= 8'h00;
      acc_reg <= 8'h00;
      sel_reg <= 1'b0;
      fdt_reg <= 16'hffff;
      rgt_reg <= 16'hffff;
    end else begin
      if (rd_valid) idx_reg <= rd_last ? 4'h0 : idx_reg + 4'h1;
      if (cd_valid) cd_idx_reg <= cd_last ? 4'h0 : cd_idx_reg + 4'h1;
      if (first_w) code_reg <= rd_byte;
      if (first_w) sel_reg <= 1'b0;
      else if (nvb_w) sel_reg <= rd_byte == TACS_NVB_SEL;
      if (rd_valid) acc_reg <= nvb_w ? 8'h00 : acc_reg ^ rd_byte;
      if (cd_valid && cd_last) fdt_reg <= 16'h0001;
      else if (fdt_reg != 16'hffff) fdt_reg <= fdt_reg + 16'h0001;
      if (req_w) rgt_reg <= 16'h0001;
      else if (rgt_reg != 16'hffff) rgt_reg <= rgt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sak_casc;
    cd_valid && cd_idx_reg == 4'h0 && sel_reg && cd_byte[TACS_SAK_CASCADE];
  endsequence
  sequence s_sak_done;
    cd_valid && cd_idx_reg == 4'h0 && sel_reg && !cd_byte[TACS_SAK_CASCADE];
  endsequence
  sequence s_next_level;
    first_w && rd_byte == code_reg + 8'h02;
  endsequence
  a_fdt_gap: assert property (first_w |-> fdt_reg >= 16'(FDT_CYC))
    else $error("reader frame inside frame delay");
  a_req_guard: assert property (req_w |-> rgt_reg >= 16'(RGT_CYC))
    else $error("requests too close");
  a_req_single: assert property (req_w |-> rd_last)
    else $error("request frame not one byte");
  a_nvb_code: assert property (nvb_w |-> rd_byte inside {8'h20, 8'h70})
    else $error("bad second command byte");
  a_ac_nocrc: assert property (nvb_w && rd_byte == TACS_NVB_AC |-> rd_last)
    else $error("anticollision frame too long");
  a_sel_len: assert property (rd_valid && rd_last && !first_w &&
    sel_reg |-> idx_reg == 4'h8) else $error("select frame length wrong");
  a_bcc_ok: assert property (rd_valid && sel_reg && idx_reg == 4'h6 |->
    rd_byte == acc_reg) else $error("select check byte wrong");
  a_atqa_two: assert property (cd_valid && cd_last && code_reg == TACS_REQ
    |-> cd_idx_reg == 4'h1) else $error("answer to request not two bytes");
  a_uid_five: assert property (cd_valid && cd_last && !sel_reg &&
    code_reg != TACS_REQ |-> cd_idx_reg == 4'h4) else $error("uid not 5 bytes");
  a_level_step: assert property (s_sak_casc |-> ##[1:NEXT_MAX] s_next_level)
    else $error("no next cascade level");
  a_sak_done: assert property (s_sak_done |=> !rd_valid [*8])
    else $error("reader went on after complete uid");
  a_coll_atqa: assert property (cd_valid && cd_coll != 16'h0 |->
    code_reg == TACS_REQ) else $error("collision outside answer to request");
endmodule

// ### tb/tb_typea_anticollision_select.sv
// Bench joining the reader and card ends through the byte link.
`timescale 1ns/1ps
module tb_typea_anticollision_select;
  import tacs_pkg::*;
  logic clk;
  logic sys_rst;
  logic start;
  logic busy;
  logic selected;
  logic failed;
  logic [79:0] uid;
  logic [1:0] uid_size;
  logic [7:0] sak;
  logic [79:0] card_uid;
  logic [1:0] card_size;
  logic mute;
  logic [15:0] coll_mask;
  logic card_selected;
  logic [7:0] rlog[$];
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  tacs_link_if tacs_link_if_i ();
  tacs_reader #(.FDT_CYC(20), .RGT_CYC(20), .TMO_CYC(20)) tacs_reader_i (
    .clk(clk), .sys_rst(sys_rst), .link(tacs_link_if_i.reader),
    .start(start), .busy(busy), .selected(selected), .failed(failed),
    .uid(uid), .uid_size(uid_size), .sak(sak));
  tacs_card tacs_card_i (.clk(clk), .sys_rst(sys_rst),
    .link(tacs_link_if_i.card), .card_uid(card_uid), .card_size(card_size),
    .mute(mute), .coll_mask(coll_mask), .card_selected(card_selected));
  tacs_properties #(.FDT_CYC(20), .RGT_CYC(20)) tacs_properties_i (
    .clk(clk), .sys_rst(sys_rst), .rd_byte(tacs_link_if_i.rd_byte),
    .rd_valid(tacs_link_if_i.rd_valid), .rd_last(tacs_link_if_i.rd_last),
    .cd_byte(tacs_link_if_i.cd_byte), .cd_valid(tacs_link_if_i.cd_valid),
    .cd_last(tacs_link_if_i.cd_last), .cd_coll(tacs_link_if_i.cd_coll));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tacs_link_if_i.rd_valid === 1'b1)
      rlog.push_back(tacs_link_if_i.rd_byte);
  end
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [15:0] crc_a(input logic [7:0] b[$]);
    logic [15:0] c;
    c = TACS_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ TACS_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // The card side may hear a muted request or not, so extra requests
  // ahead of the first anticollision frame are counted and dropped.
  task automatic run(input logic [1:0] sz, input logic [79:0] id,
    input logic [15:0] cm, input logic mu);
    logic [7:0] fr[$];
    logic [15:0] c;
    int p;
    int n;
    logic [79:0] eu;
    exp_q = {TACS_REQ};
    eu = 80'h0;
    p = 3 * sz + 3;
    for (int l = 0; l <= sz; l++) begin
      fr = {TACS_SEL_L1 + 8'(2 * l), TACS_NVB_AC};
      exp_q = {exp_q, fr};
      fr[1] = TACS_NVB_SEL;
      if (l < sz) fr.push_back(TACS_CT);
      while (fr.size() < 6) begin
        fr.push_back(id[8 * p +: 8]);
        p--;
      end
      fr.push_back(fr[2] ^ fr[3] ^ fr[4] ^ fr[5]);
      eu = {eu[47:0], fr[2], fr[3], fr[4], fr[5]};
      c = crc_a(fr);
      fr.push_back(c[7:0]);
      fr.push_back(c[15:8]);
      exp_q = {exp_q, fr};
    end
    @(posedge clk);
    #2;
    card_uid = id;
    card_size = sz;
    coll_mask = cm;
    mute = mu;
    rlog.delete();
    start = 1'b1;
    @(posedge clk);
    #2 start = 1'b0;
    for (int i = 0; i < 3000 && mu && rlog.size() < 2; i++) @(posedge clk);
    #2 mute = 1'b0;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    #2;
    n = 0;
    while (rlog.size() > 1 && rlog[1] === TACS_REQ) begin
      void'(rlog.pop_front());
      n++;
    end
    check(n >= int'(mu), "no repeated request");
    check(selected === 1'b1 && failed === 1'b0, "not selected");
    check(card_selected === 1'b1, "card not selected");
    check(uid_size === sz, "uid size");
    check(busy === 1'b0, "run timed out");
    check(uid === eu, "uid value");
    check(sak[TACS_SAK_CASCADE] === 1'b0, "sak cascade");
    check(rlog.size() == exp_q.size(), "frame count");
    foreach (exp_q[i])
      if (i < rlog.size()) check(rlog[i] === exp_q[i], "reader byte");
  endtask
  initial begin
    #(25 * 30000);
    error_cnt++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    card_uid = 80'h0;
    card_size = 2'h0;
    mute = 1'b0;
    coll_mask = 16'h0;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    check(busy === 1'b0 && selected === 1'b0 && failed === 1'b0, "reset");
    run(TACS_SIZE_SINGLE, 80'h11223344, 16'h0000, 1'b0);
    run(TACS_SIZE_DOUBLE, 80'ha1b2c3d4e5f607, 16'h0000, 1'b0);
    run(TACS_SIZE_TRIPLE, 80'h0102030405060708090a, 16'h0, 1'b0);
    run(TACS_SIZE_SINGLE, 80'h5a6b7c8d, 16'h8001, 1'b0);
    run(TACS_SIZE_SINGLE, 80'hdeadbeef, 16'h0000, 1'b1);
    close_out();
  end
endmodule
